// File: amf_pkg.sv
package amf_pkg;

  // ---------------------------------------------------------------
  // Register map (printed offsets are word indexes)
  // ---------------------------------------------------------------
  localparam logic [3:0]  IDX_OPMODE   = 4'h6;
  localparam logic [3:0]  IDX_FILTER   = 4'h7;
  localparam logic [11:0] ADDR_OPMODE  = {6'h00, IDX_OPMODE, 2'b00};
  localparam logic [11:0] ADDR_FILTER  = {6'h00, IDX_FILTER, 2'b00};
  localparam logic [11:0] ADDR_STATUS  = 12'h040;

  localparam logic [7:0]  OPMODE_RST   = 8'h00;
  localparam logic [7:0]  FILTER_RST   = 8'h00;
  localparam logic [7:0]  OPMODE_WMASK = 8'hbf;
  localparam logic [7:0]  FILTER_WMASK = 8'hff;

  localparam int BIT_EXT   = 7;
  localparam int BIT_SDO   = 5;
  localparam int BIT_STM   = 3;
  localparam int BIT_SPEED = 2;
  localparam int BIT_STBY  = 1;
  localparam int BIT_POWER_DOWN_REQUEST  = 0;
  localparam int BIT_DLY   = 5;

  // Delay code to modulator periods; value arbitrary pending full mapping
  localparam logic [7:0] DLY_STEP = 8'h04;

  // Modulator clock enables from 40 MHz: high speed 1/2, low speed 1/16
  localparam logic [3:0] MOD_DIV_HS = 4'h1;
  localparam logic [3:0] MOD_DIV_LS = 4'hf;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    START_STARTSTOP = 2'b00,
    START_ONESHOT   = 2'b01,
    START_SYNC      = 2'b10,
    START_RSVD      = 2'b11
  } amf_start_e;

  typedef enum logic [3:0] {
    FAM_WIDEBAND = 4'h1,
    FAM_SINC4    = 4'h2,
    FAM_SINC3    = 4'h4,
    FAM_NONE     = 4'h8
  } amf_fam_e;

  typedef enum logic [4:0] {
    ST_OFF     = 5'b00001,
    ST_IDLE    = 5'b00010,
    ST_STANDBY = 5'b00100,
    ST_DELAY   = 5'b01000,
    ST_CONV    = 5'b10000
  } amf_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } amf_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } amf_apb_rsp_s;

  typedef struct packed {
    amf_fam_e    family;
    logic [15:0] osr1;
    logic        sinc1_on;
    logic [9:0]  osr2;
  } amf_filt_s;

endpackage

// File: amf_filt_dec.sv
`timescale 1ns/1ps
module amf_filt_dec (
  input  wire logic [4:0]         i_code,
  output amf_pkg::amf_filt_s      o_filt
);
  import amf_pkg::*;

  always_comb begin
    o_filt = '{FAM_NONE, 16'h0000, 1'b0, 10'h000};
    if (i_code <= 5'h07) begin
      o_filt.family = FAM_WIDEBAND; // RULE11
      o_filt.osr1   = 16'h0020 << i_code[2:0];
    end else if (i_code <= 5'h0a) begin
      o_filt.family = FAM_SINC4; // RULE12
      case (i_code[1:0])
        2'b00:   o_filt.osr1 = 16'h000c;
        2'b01:   o_filt.osr1 = 16'h0010;
        default: o_filt.osr1 = 16'h0018;
      endcase
    end else if (i_code <= 5'h12) begin
      o_filt.family = FAM_SINC4; // RULE14
      o_filt.osr1   = 16'h0020 << 3'(i_code - 5'h0b);
    end else if (i_code <= 5'h1b) begin
      o_filt.family   = FAM_SINC4; // RULE15
      o_filt.osr1     = 16'h0020;
      o_filt.sinc1_on = 1'b1;
      case (i_code)
        5'h13:   o_filt.osr2 = 10'h002;
        5'h14:   o_filt.osr2 = 10'h004;
        5'h15:   o_filt.osr2 = 10'h00a;
        5'h16:   o_filt.osr2 = 10'h014;
        5'h17:   o_filt.osr2 = 10'h028;
        5'h18:   o_filt.osr2 = 10'h064;
        5'h19:   o_filt.osr2 = 10'h0c8;
        5'h1a:   o_filt.osr2 = 10'h190;
        default: o_filt.osr2 = 10'h3e8;
      endcase
    end else begin
      o_filt.family = FAM_SINC3; // RULE16
      o_filt.osr1   = (i_code == 5'h1c) ? 16'h682b : 16'h7d00;
      if (i_code[1]) begin
        o_filt.sinc1_on = 1'b1;
        o_filt.osr2     = i_code[0] ? 10'h005 : 10'h003;
      end
    end
  end

endmodule

// File: amf_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: range-extension bit set widens input range by 25 percent; resets to zero.
// RULE2: output-pin function bit: 0 data only, 1 data plus data-ready.
// RULE3: host sets data-only pin function before running a daisy chain.
// RULE4: start-pin field: 00 start/stop, 01 one-shot, 10 synchronized, 11 reserved.
// RULE5: speed bit 0 selects 25.6 MHz high speed, 1 selects 3.2 MHz low speed; here the enable is system clock / 2 and / 16.
// RULE6: standby-select set enters standby automatically once conversions stop.
// RULE7: standby-select clear keeps device fully powered idle after conversions stop.
// RULE8: automatic standby is left as soon as conversions restart.
// RULE9: power-down powers all but serial interface and regulator; registers kept.
// RULE10: filter field bits 4:0 select family and oversampling ratio.
// RULE11: codes 00000 to 00111 give wideband, ratios 32 to 4096.
// RULE12: codes 01000 to 01010 give sinc4 ratios 12, 16, 24.
// RULE13: filter field resets to 00000, wideband ratio 32.
// RULE14: codes 01011 to 10010 give sinc4 ratios 32 to 4096.
// RULE15: codes 10011 to 11011 give sinc4 32 plus sinc1 2 to 1000.
// RULE16: codes 11100 to 11111 give sinc3 and sinc3 plus sinc1 settings.
// RULE17: bits 7:5 delay first conversion by modulator clock periods.
// RULE18: reserved bits read zero, ignore writes; reserved start code undefined.
module amf_core (
  input  wire logic                 I_CLK_SYS,
  input  wire logic                 I_SYS_RST,
  input  wire amf_pkg::amf_apb_req_s I_APB,
  output amf_pkg::amf_apb_rsp_s     O_APB,
  input  wire logic                 I_CONV_RUN,
  input  wire logic                 I_CONV_DONE,
  output logic                      O_RANGE_EXTEND,
  output logic                      O_PIN_DUAL_MODE,
  output amf_pkg::amf_start_e       O_START_MODE,
  output logic                      O_LOW_SPEED,
  output logic                      O_MOD_CLK_EN,
  output logic                      O_ANALOG_ON,
  output logic                      O_STANDBY,
  output logic                      O_CONV_ENABLE,
  output amf_pkg::amf_filt_s        O_FILTER
);
  import amf_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers and register state
  // ---------------------------------------------------------------
  logic [1:0] run_sync_q;
  logic [1:0] done_sync_q;
  logic       run_q;
  logic       done_q;
  logic       run_d1_q;
  logic [7:0] opmode_q;
  logic [7:0] filter_q;
  logic [3:0] div_q;
  logic       mod_tick_q;
  logic [7:0] dly_cnt_q;
  amf_state_e state_q;
  amf_state_e state_d;
  amf_filt_s  filt_dec;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;

  function automatic logic [7:0] delay_periods(input logic [2:0] code);
    delay_periods = 8'(code * DLY_STEP);
  endfunction

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      run_sync_q  <= 2'b00;
      done_sync_q <= 2'b00;
    end else begin
      run_sync_q  <= {run_sync_q[0], I_CONV_RUN};
      done_sync_q <= {done_sync_q[0], I_CONV_DONE};
    end
  end

  assign run_q  = run_sync_q[1];
  assign done_q = done_sync_q[1];

  // ---------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped address
  // ---------------------------------------------------------------
  assign addr_ok = (I_APB.paddr == ADDR_OPMODE) || (I_APB.paddr == ADDR_FILTER) ||
                   (I_APB.paddr == ADDR_STATUS);
  assign wr_en   = I_APB.psel && I_APB.penable && I_APB.pwrite;
  assign rd_en   = I_APB.psel && !I_APB.penable && !I_APB.pwrite;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      opmode_q <= OPMODE_RST; // RULE1
      filter_q <= FILTER_RST; // RULE13
    end else if (wr_en) begin
      // Reserved bit 6 is masked so it can never be set
      if (I_APB.paddr == ADDR_OPMODE)
        opmode_q <= I_APB.pwdata[7:0] & OPMODE_WMASK; // RULE18
      if (I_APB.paddr == ADDR_FILTER)
        filter_q <= I_APB.pwdata[7:0] & FILTER_WMASK; // RULE10
    end
  end

  // Read data staged in the setup cycle so prdata comes from a flop
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      O_APB <= '{1'b0, 1'b0, 32'h0000_0000};
    end else begin
      O_APB.pready  <= I_APB.psel && !I_APB.penable;
      O_APB.pslverr <= I_APB.psel && !I_APB.penable && !addr_ok;
      if (rd_en) begin
        case (I_APB.paddr)
          ADDR_OPMODE: O_APB.prdata <= {24'h000000, opmode_q}; // RULE18
          ADDR_FILTER: O_APB.prdata <= {24'h000000, filter_q};
          ADDR_STATUS: O_APB.prdata <= {27'h0000000, state_q};
          default:     O_APB.prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Modulator clock enable follows the speed mode
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      div_q      <= 4'h0;
      mod_tick_q <= 1'b0;
    end else if (opmode_q[BIT_POWER_DOWN_REQUEST]) begin
      div_q      <= 4'h0;
      mod_tick_q <= 1'b0;
    end else begin
      // Exact 25.6/3.2 MHz needs its own source; this keeps the 8:1 ratio
      if (div_q >= (opmode_q[BIT_SPEED] ? MOD_DIV_LS : MOD_DIV_HS)) begin // RULE5
        div_q      <= 4'h0;
        mod_tick_q <= 1'b1;
      end else begin
        div_q      <= div_q + 4'h1;
        mod_tick_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Power and conversion state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (!opmode_q[BIT_POWER_DOWN_REQUEST])
          state_d = ST_IDLE;
      end
      ST_IDLE, ST_STANDBY: begin
        if (run_q && !run_d1_q)
          state_d = ST_DELAY; // RULE8
        else if (state_q == ST_IDLE && opmode_q[BIT_STBY])
          state_d = ST_STANDBY; // RULE6
        else if (state_q == ST_STANDBY && !opmode_q[BIT_STBY])
          state_d = ST_IDLE; // RULE7
      end
      ST_DELAY: begin
        if (!run_q)
          state_d = opmode_q[BIT_STBY] ? ST_STANDBY : ST_IDLE;
        else if (dly_cnt_q == 8'h00)
          state_d = ST_CONV; // RULE17
      end
      ST_CONV: begin
        // Stop takes effect only once the current conversion completes
        if (!run_q && done_q)
          state_d = opmode_q[BIT_STBY] ? ST_STANDBY : ST_IDLE; // RULE6
      end
      default: state_d = ST_IDLE;
    endcase
    if (opmode_q[BIT_POWER_DOWN_REQUEST])
      state_d = ST_OFF; // RULE9
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      state_q  <= ST_IDLE;
      run_d1_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      run_d1_q <= run_q;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      dly_cnt_q <= 8'h00;
    end else if (state_q != ST_DELAY) begin
      dly_cnt_q <= delay_periods(filter_q[7:BIT_DLY]); // RULE17
    end else if (mod_tick_q && dly_cnt_q != 8'h00) begin
      dly_cnt_q <= dly_cnt_q - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Field outputs
  // ---------------------------------------------------------------
  amf_filt_dec u_filt_dec (
    .i_code (filter_q[4:0]),
    .o_filt (filt_dec)
  );

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      O_RANGE_EXTEND  <= 1'b0;
      O_PIN_DUAL_MODE <= 1'b0;
      O_START_MODE    <= START_STARTSTOP;
      O_LOW_SPEED     <= 1'b0;
      O_MOD_CLK_EN    <= 1'b0;
      O_ANALOG_ON     <= 1'b1;
      O_STANDBY       <= 1'b0;
      O_CONV_ENABLE   <= 1'b0;
      O_FILTER        <= '{FAM_WIDEBAND, 16'h0020, 1'b0, 10'h000};
    end else begin
      O_RANGE_EXTEND  <= opmode_q[BIT_EXT]; // RULE1
      O_PIN_DUAL_MODE <= opmode_q[BIT_SDO]; // RULE2
      O_START_MODE    <= amf_start_e'(opmode_q[BIT_STM +: 2]); // RULE4
      O_LOW_SPEED     <= opmode_q[BIT_SPEED]; // RULE5
      O_MOD_CLK_EN    <= mod_tick_q;
      O_ANALOG_ON     <= (state_d != ST_OFF) && (state_d != ST_STANDBY); // RULE9
      O_STANDBY       <= (state_d == ST_STANDBY); // RULE6
      O_CONV_ENABLE   <= (state_d == ST_CONV);
      O_FILTER        <= filt_dec; // RULE10
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_power_down_request_forces_off: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // RULE9
    opmode_q[BIT_POWER_DOWN_REQUEST] |=> state_q == ST_OFF ##1 !O_ANALOG_ON)
    else $error("power-down did not switch analog off");
  chk_stby_auto_enter: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // RULE6
    (state_q == ST_CONV && !run_q && done_q && opmode_q[BIT_STBY] && !opmode_q[BIT_POWER_DOWN_REQUEST])
      |=> ##1 O_STANDBY)
    else $error("standby not entered after stop");
  chk_idle_stays_on: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // RULE7
    (!opmode_q[BIT_STBY] && !opmode_q[BIT_POWER_DOWN_REQUEST] && $past(!opmode_q[BIT_STBY])) |-> ##1 O_ANALOG_ON)
    else $error("idle mode powered down");
  chk_stby_exit_run: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // RULE8
    (state_q == ST_STANDBY && run_q && !run_d1_q && !opmode_q[BIT_POWER_DOWN_REQUEST]) |=> state_q == ST_DELAY)
    else $error("restart did not leave standby");
  chk_rsvd_bit_zero: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // RULE18
    !opmode_q[6] && (O_APB.prdata[31:8] == 24'h000000))
    else $error("reserved bit not zero");
  chk_range_follow: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // RULE1
    $rose(opmode_q[BIT_EXT]) |=> O_RANGE_EXTEND)
    else $error("range extension not applied");
  // The tick two cycles on is decided by the mode sampled in between, so that is what qualifies it
  chk_speed_div: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // RULE5
    (mod_tick_q && $stable(opmode_q)) ##1 (!opmode_q[BIT_SPEED] && !opmode_q[BIT_POWER_DOWN_REQUEST] && $stable(opmode_q))
      |-> !mod_tick_q ##1 mod_tick_q)
    else $error("high-speed tick rate wrong");
  chk_filter_rst: assert property (@(posedge I_CLK_SYS) // RULE13
    $past(I_SYS_RST) |-> filter_q == 8'h00 && O_FILTER.osr1 == 16'h0020)
    else $error("filter reset value wrong");
  chk_delay_first: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // RULE17
    (state_q == ST_DELAY && dly_cnt_q != 8'h00) |=> state_q != ST_CONV)
    else $error("conversion started before delay");
  chk_output_pin_function_select: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // RULE2
    $past(opmode_q[BIT_SDO]) == O_PIN_DUAL_MODE)
    else $error("pin function mismatch");

  cov_conv: cover property (@(posedge I_CLK_SYS) state_q == ST_DELAY ##1 state_q == ST_CONV);
  cov_standby: cover property (@(posedge I_CLK_SYS) state_q == ST_STANDBY);
  cov_power_down_request: cover property (@(posedge I_CLK_SYS) state_q == ST_OFF);
  cov_sinc3: cover property (@(posedge I_CLK_SYS) O_FILTER.family == FAM_SINC3);

endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  import amf_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic         clk;
  logic         rst;
  logic         run;
  logic         done;
  amf_apb_req_s req;
  amf_apb_rsp_s rsp;
  logic         rng;
  logic         dual;
  amf_start_e   smode;
  logic         lows;
  logic         tick;
  logic         ana;
  logic         stby;
  logic         conv;
  amf_filt_s    filt;
  logic [32:0]  exp_q[$];
  int           mismatches;
  int           n_compared;
  int           seed;
  int           n;
  logic [7:0]   v;

  amf_core u_dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_APB(req), .O_APB(rsp), .I_CONV_RUN(run),
    .I_CONV_DONE(done), .O_RANGE_EXTEND(rng), .O_PIN_DUAL_MODE(dual), .O_START_MODE(smode),
    .O_LOW_SPEED(lows), .O_MOD_CLK_EN(tick), .O_ANALOG_ON(ana), .O_STANDBY(stby),
    .O_CONV_ENABLE(conv), .O_FILTER(filt));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  task automatic fail_wait(input string what);
    mismatches++;
    $display("unexpected %s: expected change, seen timeout", what);
    complete_run();
  endtask

  // Expectation {pslverr, prdata} queued before the request goes out
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
    int i;
    exp_q.push_back(e);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= {24'($random(seed)), d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 20) fail_wait("pready");
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_sig(input logic s, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk);
      if ((s ? stby : conv) === lvl) break;
    end
    if (i == lim) fail_wait(s ? "standby" : "conv enable");
  endtask

  task automatic count_ticks(output int c);
    c = 0;
    repeat (64) begin
      @(posedge clk);
      if (tick === 1'b1) c++;
    end
  endtask

  function automatic amf_filt_s exp_filt(input logic [4:0] c);
    logic [9:0] r2 [9];
    r2 = '{10'd2, 10'd4, 10'd10, 10'd20, 10'd40, 10'd100, 10'd200, 10'd400, 10'd1000};
    exp_filt = '0;
    exp_filt.family = FAM_SINC4;
    exp_filt.osr1 = 16'd32;
    if (c < 5'd8) begin
      exp_filt.family = FAM_WIDEBAND;
      exp_filt.osr1 = 16'd32 << c;
    end else if (c < 5'd11) begin
      exp_filt.osr1 = (c == 5'd8) ? 16'd12 : (c == 5'd9) ? 16'd16 : 16'd24;
    end else if (c < 5'd19) begin
      exp_filt.osr1 = 16'd32 << (c - 5'd11);
    end else if (c < 5'd28) begin
      exp_filt.sinc1_on = 1'b1;
      exp_filt.osr2 = r2[c - 5'd19];
    end else begin
      exp_filt.family = FAM_SINC3;
      exp_filt.osr1 = (c == 5'd28) ? 16'd26667 : 16'd32000;
      exp_filt.sinc1_on = c > 5'd29;
      exp_filt.osr2 = (c == 5'd30) ? 10'd3 : 10'd5;
    end
  endfunction

  // Response monitor: oldest note against each completed transfer
  always @(posedge clk) begin
    if (req.psel && req.penable && rsp.pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail_wait("unqueued response");
      end else begin
        check("pslverr", {31'h0, exp_q[0][32]}, {31'h0, rsp.pslverr});
        if (!req.pwrite) check("prdata", exp_q[0][31:0], rsp.prdata);
        void'(exp_q.pop_front());
      end
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    amf_filt_s ef;
    seed = 32'h598ea0b9;
    mismatches = 0;
    n_compared = 0;
    rst = 1'b1;
    run = 1'b0;
    done = 1'b0;
    req = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, ADDR_OPMODE, 8'h00, 33'h0);
    apb(1'b0, ADDR_FILTER, 8'h00, 33'h0);
    check("filter osr1", 32'd32, {16'h0, filt.osr1});
    check("filter family", {28'h0, FAM_WIDEBAND}, {28'h0, filt.family});
    $display("test reset values done");
    for (int sm = 0; sm < 4; sm++) begin
      v = (8'($random(seed)) & 8'ha4) | 8'h40 | 8'(sm << 3);
      apb(1'b1, ADDR_OPMODE, v, 33'h0);
      apb(1'b0, ADDR_OPMODE, 8'h00, {25'h0, v & 8'hbf});
      check("range extend", {31'h0, v[7]}, {31'h0, rng});
      check("pin dual", {31'h0, v[5]}, {31'h0, dual});
      check("start mode", sm, {30'h0, smode});
      check("low speed", {31'h0, v[2]}, {31'h0, lows});
    end
    apb(1'b1, 12'h020, 8'h5a, {1'b1, 32'h0});
    apb(1'b0, 12'h020, 8'h00, {1'b1, 32'h0});
    $display("test opmode fields done");
    for (int c = 0; c < 32; c++) begin
      v = {3'($random(seed)), 5'(c)};
      ef = exp_filt(5'(c));
      apb(1'b1, ADDR_FILTER, v, 33'h0);
      apb(1'b0, ADDR_FILTER, 8'h00, {25'h0, v});
      repeat (2) @(posedge clk);
      check("filter family", {28'h0, ef.family}, {28'h0, filt.family});
      check("filter osr1", {16'h0, ef.osr1}, {16'h0, filt.osr1});
      check("filter sinc1", {31'h0, ef.sinc1_on}, {31'h0, filt.sinc1_on});
      if (ef.sinc1_on) check("filter osr2", {22'h0, ef.osr2}, {22'h0, filt.osr2});
    end
    $display("test filter table done");
    apb(1'b1, ADDR_OPMODE, 8'h00, 33'h0);
    count_ticks(n);
    check("ticks high speed", 32'd32, n);
    apb(1'b1, ADDR_OPMODE, 8'h04, 33'h0);
    count_ticks(n);
    check("ticks low speed", 32'd4, n);
    apb(1'b1, ADDR_OPMODE, 8'h00, 33'h0);
    apb(1'b1, ADDR_FILTER, 8'h00, 33'h0);
    $display("test speed done");
    run <= 1'b1;
    wait_sig(1'b0, 1'b1, 200);
    run <= 1'b0;
    done <= 1'b1;
    wait_sig(1'b0, 1'b0, 50);
    done <= 1'b0;
    repeat (4) @(posedge clk);
    check("idle standby", 32'h0, {31'h0, stby});
    check("idle analog", 32'h1, {31'h0, ana});
    apb(1'b1, ADDR_OPMODE, 8'h02, 33'h0);
    apb(1'b1, ADDR_FILTER, 8'he0, 33'h0);
    check("auto standby", 32'h1, {31'h0, stby});
    check("standby analog", 32'h0, {31'h0, ana});
    run <= 1'b1;
    wait_sig(1'b1, 1'b0, 20);
    repeat (20) @(posedge clk);
    check("delayed start", 32'h0, {31'h0, conv});
    wait_sig(1'b0, 1'b1, 400);
    run <= 1'b0;
    done <= 1'b1;
    wait_sig(1'b1, 1'b1, 50);
    done <= 1'b0;
    run <= 1'b1;
    wait_sig(1'b0, 1'b1, 400);
    $display("test standby and delay done");
    apb(1'b1, ADDR_OPMODE, 8'h03, 33'h0);
    // The tick launched on the write edge still uses the old mode
    @(posedge clk);
    count_ticks(n);
    check("ticks in power-down", 32'd0, n);
    check("power-down analog", 32'h0, {31'h0, ana});
    check("power-down conv", 32'h0, {31'h0, conv});
    apb(1'b0, ADDR_OPMODE, 8'h00, 33'h03);
    apb(1'b0, ADDR_FILTER, 8'h00, 33'he0);
    apb(1'b0, ADDR_STATUS, 8'h00, 33'h01);
    run <= 1'b0;
    $display("test power-down done");
    complete_run();
  end
endmodule
